/* hw/fephy_clkdiv.v */
`default_nettype none
`include "fephy_consts.vh"
// ==========================================
// nibble clock divider off the 125 MHz bit clock, re-phased by align_in
module fephy_clkdiv #(
	parameter DIV = `FEPHY_NIBBLE_DIV,
	parameter HIGH = `FEPHY_NIBBLE_HIGH
) (
	input wire mclk_in,
	input wire reset_n_in,
	input wire ce_in,
	input wire align_in,
	output reg clk_out,
	output wire rise_out,
	output wire fall_out
);
	reg [3:0] count_ff;
	reg pend_ff;
	wire [3:0] nxt_count;
	wire do_align;
	// an align seen while the clock is high waits for the low phase,
	// so a re-phase never stretches the high time
	assign do_align = (align_in || pend_ff) && !clk_out;
	// align forces phase zero, where the output clock rises
	assign nxt_count = (do_align || count_ff == DIV[3:0] - 4'h1) ? 4'h0 : count_ff + 4'h1;
	assign rise_out = ce_in && (nxt_count == 4'h0) && !clk_out;
	assign fall_out = ce_in && (nxt_count == HIGH[3:0]) && clk_out;
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			// last phase, so the first edge after reset starts a full high time
			count_ff <= DIV[3:0] - 4'h1;
			clk_out <= 1'b0;
			pend_ff <= 1'b0;
		end else if (ce_in) begin
			count_ff <= nxt_count;
			pend_ff <= (align_in || pend_ff) && clk_out;
			clk_out <= (nxt_count < HIGH[3:0]);
		end
	end
endmodule // fephy_clkdiv
`default_nettype wire

/* hw/fephy_consts.vh */
`ifndef FEPHY_CONSTS_VH
`define FEPHY_CONSTS_VH
// ==========================================
// clocking
`define FEPHY_CLK_PERIOD_NS 8
`define FEPHY_NIBBLE_DIV 5
`define FEPHY_NIBBLE_HIGH 2
`define FEPHY_MDC_MIN_PERIOD_NS 400
`define FEPHY_MDC_MIN_CYC ((`FEPHY_MDC_MIN_PERIOD_NS + `FEPHY_CLK_PERIOD_NS - 1) / `FEPHY_CLK_PERIOD_NS)
// ==========================================
// register map, word index on a 4-bit address
`define FEPHY_ADDR_W 4
`define FEPHY_REG_CTRL 4'h0
`define FEPHY_REG_STATUS 4'h1
`define FEPHY_REG_INT_STAT 4'h2
`define FEPHY_REG_INT_EN 4'h3
`define FEPHY_REG_INT_CLR 4'h4
`define FEPHY_CTRL_RESET 4'h0
// control fields
`define FEPHY_CTRL_REPEATER 0
`define FEPHY_CTRL_HALF_DUPLEX 1
`define FEPHY_CTRL_FULL_DUPLEX 2
`define FEPHY_CTRL_LOOPBACK 3
// interrupt fields
`define FEPHY_INT_W 5
`define FEPHY_INT_COL 0
`define FEPHY_INT_RX_ERR 1
`define FEPHY_INT_TX_HALT 2
`define FEPHY_INT_LINE_LOST 3
`define FEPHY_INT_MDC_FAST 4
`endif

/* hw/fephy_mii.v */
// Notes on behaviour
// - a 25 MHz reference input sets the phase of the transmit nibble clock
// - tx clock out is 25 MHz, derived from the 125 MHz bit clock
// - transmit nibble captured on every rising transmit clock edge
// - tx enable with tx error sends halt code groups continuously
// - tx error is ignored while tx enable is low
// - receive nibble changes on falling rx clock; mac samples on rising
// - rx clock is 25 MHz, aligned to recovered 125 MHz bit clock
// - without valid line signal, rx clock aligns to the reference clock
// - standard mode: carrier on receive non-idle or own transmit
// - repeater or half duplex: carrier only from receive non-idle
// - collision output follows the collision, registered one clock later
// - collision output held low in full duplex or loopback
// - rx data valid high while a packet is received
// - rx error flags bad code groups in packet or corrupt idle
// - management data sampled on rising management clock edges
`default_nettype none
`include "fephy_consts.vh"
module fephy_mii #(
	parameter MDC_MIN_CYC = `FEPHY_MDC_MIN_CYC
) (
	input wire mclk_in,
	input wire reset_n_in,
	input wire ce_in,
	// register port
	input wire [`FEPHY_ADDR_W-1:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [31:0] reg_rdata_out,
	output reg irq_out,
	// mii transmit pins
	input wire tx_reference_clock_in,
	input wire [3:0] txd_in,
	input wire tx_en_in,
	input wire tx_er_in,
	output wire tx_clk_out,
	// mii receive pins
	output wire rx_clk_out,
	output reg [3:0] rxd_out,
	output reg rx_dv_out,
	output reg rx_er_out,
	output reg crs_out,
	output reg col_out,
	// management pins
	input wire mdc_in,
	input wire mdio_in,
	output reg mdio_out,
	output reg mdio_oe_n_out,
	// to the encoder
	output reg [3:0] enc_nibble_out,
	output reg enc_valid_out,
	output reg enc_halt_out,
	// from clock recovery and decoder, same clock
	input wire line_receive_pair_valid_in,
	input wire rx_symbol_align_in,
	input wire [3:0] dec_nibble_in,
	input wire dec_in_packet_in,
	input wire dec_code_error_in,
	input wire dec_idle_corrupt_in,
	input wire dec_non_idle_in,
	// management register block
	input wire mgmt_tx_bit_in,
	input wire mgmt_drive_in,
	output reg mgmt_rx_bit_out,
	output reg mgmt_rx_strobe_out
);
	// ==========================================
	// pin synchronisers
	wire [8:0] pins_s;
	wire [3:0] txd_s;
	wire tx_en_s;
	wire tx_er_s;
	wire ref_s;
	wire mdc_s;
	wire mdio_s;
	reg ref_d_ff;
	reg mdc_d_ff;
	wire ref_rise;
	wire mdc_rise;
	wire mdc_fall;

	fephy_sync3 #(.W(9)) u_sync (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.async_in({mdio_in, mdc_in, tx_reference_clock_in, tx_er_in, tx_en_in, txd_in}),
		.stable_out(pins_s)
	);
	assign txd_s = pins_s[3:0];
	assign tx_en_s = pins_s[4];
	assign tx_er_s = pins_s[5];
	assign ref_s = pins_s[6];
	assign mdc_s = pins_s[7];
	assign mdio_s = pins_s[8];

	// edge finders on the settled copies only
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ref_d_ff <= 1'b0;
			mdc_d_ff <= 1'b0;
		end else if (ce_in) begin
			ref_d_ff <= ref_s;
			mdc_d_ff <= mdc_s;
		end
	end
	assign ref_rise = ce_in && ref_s && !ref_d_ff;
	assign mdc_rise = ce_in && mdc_s && !mdc_d_ff;
	assign mdc_fall = ce_in && !mdc_s && mdc_d_ff;

	// ==========================================
	// nibble clocks
	wire tx_rise;
	wire rx_fall;
	wire rx_align;

	// transmit clock divides the bit clock and follows the reference phase
	fephy_clkdiv u_txdiv (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.align_in(ref_rise),
		.clk_out(tx_clk_out),
		.rise_out(tx_rise),
		.fall_out()
	);

	// receive clock follows the line, else falls back to the reference
	assign rx_align = line_receive_pair_valid_in ? rx_symbol_align_in : ref_rise;
	fephy_clkdiv u_rxdiv (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.align_in(rx_align),
		.clk_out(rx_clk_out),
		.rise_out(),
		.fall_out(rx_fall)
	);

	// ==========================================
	// control register
	reg [3:0] ctrl_ff;
	wire standard_mode;
	wire no_col_mode;
	assign standard_mode = !ctrl_ff[`FEPHY_CTRL_REPEATER] && !ctrl_ff[`FEPHY_CTRL_HALF_DUPLEX];
	assign no_col_mode = ctrl_ff[`FEPHY_CTRL_FULL_DUPLEX] || ctrl_ff[`FEPHY_CTRL_LOOPBACK];

	// ==========================================
	// transmit capture
	reg tx_active_ff;
	// synced data settles four cycles after the pins move, one cycle before the next rise; it is taken as the tx clock rises.
	// the mac must keep tx enable aligned to tx clock for this to hold.
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			enc_nibble_out <= 4'h0;
			enc_valid_out <= 1'b0;
			enc_halt_out <= 1'b0;
			tx_active_ff <= 1'b0;
		end else if (tx_rise) begin
			tx_active_ff <= tx_en_s;
			enc_halt_out <= tx_en_s && tx_er_s;
			enc_valid_out <= tx_en_s && !tx_er_s;
			enc_nibble_out <= tx_en_s ? txd_s : 4'h0;
		end
	end

	// ==========================================
	// receive nibble output, changed on the falling rx clock
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rxd_out <= 4'h0;
			rx_dv_out <= 1'b0;
			rx_er_out <= 1'b0;
		end else if (rx_fall) begin
			rxd_out <= dec_in_packet_in ? dec_nibble_in : 4'h0;
			rx_dv_out <= dec_in_packet_in;
			// code errors count inside a packet, corrupt idle outside
			rx_er_out <= dec_in_packet_in ? dec_code_error_in : dec_idle_corrupt_in;
		end
	end

	// ==========================================
	// carrier and collision
	wire collision;
	assign collision = tx_active_ff && dec_non_idle_in && !no_col_mode;
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			crs_out <= 1'b0;
			col_out <= 1'b0;
		end else if (ce_in) begin
			crs_out <= dec_non_idle_in || (standard_mode && tx_active_ff);
			col_out <= collision;
		end
	end

	// ==========================================
	// management pins
	reg [7:0] mdc_gap_ff;
	wire mdc_too_fast;
	// gap saturates so a slow mdc never wraps into a false alarm
	assign mdc_too_fast = mdc_rise && (mdc_gap_ff < MDC_MIN_CYC[7:0]);
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mdc_gap_ff <= 8'hff;
			mgmt_rx_bit_out <= 1'b0;
			mgmt_rx_strobe_out <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe_n_out <= 1'b1;
		end else if (ce_in) begin
			mgmt_rx_strobe_out <= mdc_rise;
			if (mdc_rise) begin
				mdc_gap_ff <= 8'h01;
				mgmt_rx_bit_out <= mdio_s;
			end else if (mdc_gap_ff != 8'hff) begin
				mdc_gap_ff <= mdc_gap_ff + 8'h01;
			end
			// drive on the falling edge so data is settled at the rise
			if (mdc_fall) begin
				mdio_out <= mgmt_tx_bit_in;
				mdio_oe_n_out <= !mgmt_drive_in;
			end
		end
	end

	// ==========================================
	// interrupt events
	reg col_d_ff;
	reg halt_d_ff;
	reg line_d_ff;
	wire [`FEPHY_INT_W-1:0] events;
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			col_d_ff <= 1'b0;
			halt_d_ff <= 1'b0;
			line_d_ff <= 1'b0;
		end else if (ce_in) begin
			col_d_ff <= col_out;
			halt_d_ff <= enc_halt_out;
			line_d_ff <= line_receive_pair_valid_in;
		end
	end
	assign events[`FEPHY_INT_COL] = ce_in && col_out && !col_d_ff;
	assign events[`FEPHY_INT_RX_ERR] = rx_fall && rx_er_out;
	assign events[`FEPHY_INT_TX_HALT] = ce_in && enc_halt_out && !halt_d_ff;
	assign events[`FEPHY_INT_LINE_LOST] = ce_in && line_d_ff && !line_receive_pair_valid_in;
	assign events[`FEPHY_INT_MDC_FAST] = mdc_too_fast;

	// ==========================================
	// register port
	reg [`FEPHY_INT_W-1:0] int_stat_ff;
	reg [`FEPHY_INT_W-1:0] int_en_ff;
	reg [`FEPHY_INT_W-1:0] clr_mask;
	reg [31:0] nxt_rdata;

	// a write to the clear register drops the named bits
	always @* begin
		clr_mask = {`FEPHY_INT_W{1'b0}};
		if (reg_wr_in && reg_addr_in == `FEPHY_REG_INT_CLR) begin
			clr_mask = reg_wdata_in[`FEPHY_INT_W-1:0];
		end
	end

	// read mux; unmapped and write-only addresses read as zero
	always @* begin
		nxt_rdata = 32'h0000_0000;
		if (reg_addr_in == `FEPHY_REG_CTRL) begin
			nxt_rdata = {28'h000_0000, ctrl_ff};
		end else if (reg_addr_in == `FEPHY_REG_STATUS) begin
			nxt_rdata = {26'h000_0000, line_receive_pair_valid_in, tx_active_ff,
				rx_dv_out, col_out, crs_out, enc_halt_out};
		end else if (reg_addr_in == `FEPHY_REG_INT_STAT) begin
			nxt_rdata = {27'h000_0000, int_stat_ff};
		end else if (reg_addr_in == `FEPHY_REG_INT_EN) begin
			nxt_rdata = {27'h000_0000, int_en_ff};
		end
	end

	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_ff <= `FEPHY_CTRL_RESET;
			int_en_ff <= {`FEPHY_INT_W{1'b0}};
			int_stat_ff <= {`FEPHY_INT_W{1'b0}};
			reg_rdata_out <= 32'h0000_0000;
			irq_out <= 1'b0;
		end else if (ce_in) begin
			if (reg_wr_in && reg_addr_in == `FEPHY_REG_CTRL) begin
				ctrl_ff <= reg_wdata_in[3:0];
			end else if (reg_wr_in && reg_addr_in == `FEPHY_REG_INT_EN) begin
				int_en_ff <= reg_wdata_in[`FEPHY_INT_W-1:0];
			end
			// a new event outranks a clear in the same cycle
			int_stat_ff <= (int_stat_ff & ~clr_mask) | events;
			reg_rdata_out <= reg_rd_in ? nxt_rdata : 32'h0000_0000;
			irq_out <= |(((int_stat_ff & ~clr_mask) | events) & int_en_ff);
		end
	end
endmodule // fephy_mii
`default_nettype wire

/* hw/fephy_sync3.v */
`default_nettype none
// ==========================================
// three-stage pin synchroniser; a bit counts once stages two and three agree
module fephy_sync3 #(
	parameter W = 1
) (
	input wire mclk_in,
	input wire reset_n_in,
	input wire ce_in,
	input wire [W-1:0] async_in,
	output reg [W-1:0] stable_out
);
	reg [W-1:0] s1_ff;
	reg [W-1:0] s2_ff;
	reg [W-1:0] s3_ff;
	integer i;
	// stage one feeds stage two only, to keep metastability contained
	always @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s1_ff <= {W{1'b0}};
			s2_ff <= {W{1'b0}};
			s3_ff <= {W{1'b0}};
			stable_out <= {W{1'b0}};
		end else if (ce_in) begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_ff[i] == s3_ff[i]) begin
					stable_out[i] <= s3_ff[i];
				end
			end
		end
	end
endmodule // fephy_sync3
`default_nettype wire

/* tb/fephy_mac_model.sv */
`default_nettype none
// ==========================================
// mac transmit side: frames of len_in nibbles, pins moved on tx clock only
module fephy_mac_model (
	input wire logic tx_clk_in,
	input wire logic go_in,
	input wire logic er_in,
	input wire logic [7:0] len_in,
	output logic tx_en_out,
	output var logic tx_er_out = 1'b0,
	output var logic [3:0] txd_out = 4'h0
);
	logic [7:0] cnt_ff = 8'h00;
	// data keeps changing when idle, so an ignored pin is really exercised
	always @(posedge tx_clk_in) begin
		txd_out <= 4'($urandom);
		tx_er_out <= er_in;
		if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
		else if (go_in) cnt_ff <= len_in;
	end
	assign tx_en_out = cnt_ff != 8'h00;
endmodule // fephy_mac_model
`default_nettype wire

/* tb/fephy_mii_monitor.sv */
`default_nettype none
// ==========================================
// port checker for the mii block
module fephy_mii_monitor (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic tx_clk_out,
	input wire logic rx_clk_out,
	input wire logic [3:0] rxd_out,
	input wire logic rx_dv_out,
	input wire logic rx_er_out,
	input wire logic crs_out,
	input wire logic col_out,
	input wire logic [3:0] enc_nibble_out,
	input wire logic enc_valid_out,
	input wire logic enc_halt_out,
	input wire logic [3:0] dec_nibble_in,
	input wire logic dec_in_packet_in,
	input wire logic dec_code_error_in,
	input wire logic dec_idle_corrupt_in,
	input wire logic dec_non_idle_in,
	input wire logic mgmt_rx_strobe_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	// nibble clock: high two cycles, then low
	sequence s_high2(c);
		c[*2] ##1 !c;
	endsequence
	a_tx_clk_duty: assert property ($rose(tx_clk_out) |-> s_high2(tx_clk_out))
		else $error("tx clock high time wrong");
	a_rx_clk_duty: assert property ($rose(rx_clk_out) |-> s_high2(rx_clk_out))
		else $error("rx clock high time wrong");
	// receive outputs move only with the falling rx clock
	a_rx_on_fall: assert property (!$stable({rxd_out, rx_dv_out, rx_er_out}) |-> $fell(rx_clk_out))
		else $error("receive outputs moved off the rx clock fall");
	a_rx_dv_packet: assert property ($fell(rx_clk_out) |-> rx_dv_out == $past(dec_in_packet_in))
		else $error("rx data valid does not follow packet");
	a_rx_er_cause: assert property ($fell(rx_clk_out) |-> rx_er_out == ($past(dec_in_packet_in) ?
		$past(dec_code_error_in) : $past(dec_idle_corrupt_in)))
		else $error("rx error does not follow its cause");
	a_rxd_nibble: assert property ($fell(rx_clk_out) |-> rxd_out == ($past(dec_in_packet_in) ?
		$past(dec_nibble_in) : 4'h0))
		else $error("rx nibble wrong");
	a_enc_on_rise: assert property (!$stable({enc_nibble_out, enc_valid_out, enc_halt_out})
		|-> $rose(tx_clk_out))
		else $error("encoder outputs moved off the tx clock rise");
	a_enc_not_both: assert property (!(enc_valid_out && enc_halt_out))
		else $error("halt and valid together");
	a_crs_on_rx: assert property (dec_non_idle_in |=> crs_out)
		else $error("carrier missing on receive activity");
	a_col_ends: assert property (!dec_non_idle_in |=> !col_out)
		else $error("collision outlived its cause");
	a_mgmt_pulse: assert property (mgmt_rx_strobe_out |=> !mgmt_rx_strobe_out)
		else $error("management strobe too long");
endmodule // fephy_mii_monitor
bind fephy_mii fephy_mii_monitor u_mon (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
	.tx_clk_out(tx_clk_out), .rx_clk_out(rx_clk_out), .rxd_out(rxd_out),
	.rx_dv_out(rx_dv_out), .rx_er_out(rx_er_out), .crs_out(crs_out), .col_out(col_out),
	.enc_nibble_out(enc_nibble_out), .enc_valid_out(enc_valid_out),
	.enc_halt_out(enc_halt_out), .dec_nibble_in(dec_nibble_in),
	.dec_in_packet_in(dec_in_packet_in), .dec_code_error_in(dec_code_error_in),
	.dec_idle_corrupt_in(dec_idle_corrupt_in), .dec_non_idle_in(dec_non_idle_in),
	.mgmt_rx_strobe_out(mgmt_rx_strobe_out));
`default_nettype wire

/* tb/testbench.sv */
`default_nettype none
`include "fephy_consts.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 0, reset_n_in = 0, refclk = 0, wr = 0, rd = 0, tx_en, tx_er, go = 0, er = 0;
	logic mdc = 0, mdio = 0, mdio_exp = 0, lv = 0, align = 0, ni = 0, rnd = 0, txb = 0, drv = 0;
	logic [3:0] addr = 4'h0, txd, dn = 4'h0;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [2:0] dp = 3'h0;
	logic [5:0] e;
	logic irq, tx_clk_out, rx_clk_out, crs, col, strobe, rbit, ev, eh;
	logic [3:0] en;
	logic [3:0] rxd;
	logic rdv, rer, mo, moe;
	logic rx_clk_d = 0;
	logic [6:0] pd = 7'h00;
	logic [3:0] modes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
	int n_errors = 0, n_compared = 0, cyc = 0;
	initial forever #4 mclk_in = ~mclk_in;
	initial forever #20 refclk = ~refclk;
	fephy_mac_model u_mac (.tx_clk_in(tx_clk_out), .go_in(go), .er_in(er), .len_in(8'd40),
		.tx_en_out(tx_en), .tx_er_out(tx_er), .txd_out(txd));
	fephy_mii #(.MDC_MIN_CYC(10)) DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .irq_out(irq), .tx_reference_clock_in(refclk), .txd_in(txd),
		.tx_en_in(tx_en), .tx_er_in(tx_er), .tx_clk_out(tx_clk_out), .rx_clk_out(rx_clk_out),
		.rxd_out(rxd), .rx_dv_out(rdv), .rx_er_out(rer), .crs_out(crs), .col_out(col),
		.mdc_in(mdc), .mdio_in(mdio), .mdio_out(mo), .mdio_oe_n_out(moe), .enc_nibble_out(en),
		.enc_valid_out(ev), .enc_halt_out(eh), .line_receive_pair_valid_in(lv),
		.rx_symbol_align_in(align), .dec_nibble_in(dn), .dec_in_packet_in(dp[0]),
		.dec_code_error_in(dp[1]), .dec_idle_corrupt_in(dp[2]), .dec_non_idle_in(ni),
		.mgmt_tx_bit_in(txb), .mgmt_drive_in(drv), .mgmt_rx_bit_out(rbit),
		.mgmt_rx_strobe_out(strobe));
	// ==========================================
	// compare, verdict
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task end_sim();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ==========================================
	// register bus: one-cycle strobes, read data the cycle after
	task wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_in) begin addr <= a; wdata <= d; wr <= 1; end
		@(posedge mclk_in) wr <= 0;
	endtask
	task rreg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge mclk_in) begin addr <= a; rd <= 1; end
		@(posedge mclk_in) rd <= 0;
		#1 check("reg_rdata", rdata, exp);
	endtask
	task cycles(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	// ==========================================
	// background stimulus and watchers
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin n_errors++; end_sim(); end
		// decoder values as the design sampled them, checked one edge after the fall
		rx_clk_d <= rx_clk_out;
		pd <= {dp, dn};
		if (rx_clk_d && !rx_clk_out) check("rx_out", {rxd, rdv, rer},
			{pd[4] ? pd[3:0] : 4'h0, pd[4], pd[4] ? pd[5] : pd[6]});
		dn <= rnd ? 4'($urandom) : 4'h0;
		dp <= rnd ? 3'($urandom) : 3'h0;
		if (strobe === 1'b1) check("mgmt_rx_bit", rbit, mdio_exp);
	end
	always @(posedge mdc) mdio_exp = mdio;
	// transmit capture: value on the pins just before the tx clock rise
	always @(posedge tx_clk_out) begin
		e = {tx_en, tx_er, txd};
		#1;
		if (e[5]) check("enc_nibble", en, e[3:0]);
		check("enc_valid", ev, e[5] & ~e[4]);
		check("enc_halt", eh, e[5] & e[4]);
	end
	task frame();
		@(posedge mclk_in) go <= 1;
		wait (tx_en === 1'b1);
		@(posedge mclk_in) go <= 0;
	endtask
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(32'h2573_b758));
		cycles(4);
		reset_n_in = 1;
		rreg(`FEPHY_REG_CTRL, 32'h0000_0000);
		rreg(`FEPHY_REG_INT_CLR, 32'h0000_0000);
		rreg(4'hf, 32'h0000_0000);
		wreg(`FEPHY_REG_INT_EN, 32'h0000_001f);
		// carrier and collision per mode
		foreach (modes[i]) begin
			wreg(`FEPHY_REG_CTRL, {28'h0, modes[i]});
			frame();
			cycles(20);
			check("crs_tx_only", crs, !(modes[i][0] | modes[i][1]));
			check("col_idle", col, 0);
			@(posedge mclk_in) ni <= 1;
			cycles(3);
			check("crs_rx", crs, 1);
			check("col", col, !(modes[i][2] | modes[i][3]));
			@(posedge mclk_in) ni <= 0;
			cycles(3);
			check("col_end", col, 0);
			wait (tx_en === 1'b0);
		end
		wreg(`FEPHY_REG_CTRL, 32'h0000_0000);
		// halt in frame, then error pin alone while idle
		er <= 1;
		frame();
		wait (tx_en === 1'b0);
		cycles(30);
		er <= 0;
		// receive with random decoder output, a re-phase, then line loss
		rnd <= 1;
		lv <= 1;
		cycles(100);
		@(negedge rx_clk_out);
		@(posedge mclk_in) align <= 1;
		@(posedge mclk_in) align <= 0;
		cycles(100);
		lv <= 0;
		rnd <= 0;
		// management clock at 64 ns, data changed on its fall; too fast on purpose
		repeat (32) begin
			cycles(4);
			// device drive from the previous fall must stand by the next one
			if (mdc) begin
				check("mdio_out", {mo, moe}, {txb, !drv});
				txb <= 1'($urandom);
				drv <= 1'($urandom);
			end
			mdio <= mdc ? 1'($urandom) : mdio;
			mdc <= ~mdc;
		end
		cycles(10);
		rreg(`FEPHY_REG_INT_STAT, 32'h0000_001f);
		check("irq_on", irq, 1);
		wreg(`FEPHY_REG_INT_EN, 32'h0000_0000);
		cycles(2);
		check("irq_masked", irq, 0);
		wreg(`FEPHY_REG_INT_CLR, 32'h0000_001f);
		rreg(`FEPHY_REG_INT_STAT, 32'h0000_0000);
		end_sim();
	end
endmodule // testbench
`default_nettype wire
